// file: hw/eipd_pkg.sv
package eipd_pkg;
   // register byte address of the status and control register
   localparam logic [3:0] EIPD_CTRL_ADDR = 4'h0;
   // field positions inside the status and control register
   localparam int EIPD_MODE_BIT = 0;
   localparam int EIPD_IE_BIT = 1;
   localparam int EIPD_ACK_BIT = 2;
   localparam int EIPD_FLAG_BIT = 3;
   localparam int EIPD_PE_BIT = 4;
   localparam int EIPD_POL_BIT = 5;
   localparam int EIPD_PDD_BIT = 6;
   // control bits after reset: everything off
   localparam logic [7:0] EIPD_CTRL_RESET = 8'h00;
   // axi response codes
   localparam logic [1:0] EIPD_RESP_OKAY = 2'h0;
   localparam logic [1:0] EIPD_RESP_SLVERR = 2'h2;
   // synchroniser depth
   localparam int EIPD_SYNC_STAGES = 2;

   // control fields held by software
   typedef struct packed {
      logic pull_device_disable;
      logic polarity_select;
      logic pin_function_enable;
      logic interrupt_enable;
      logic detect_mode_select;
   } eipd_ctrl_t;

   // pad control towards the pin
   typedef struct packed {
      logic pull_enable;
      logic pull_up;
   } eipd_pad_t;
endpackage

// file: hw/eipd_sync.sv
`timescale 1ns/1ns
// two flip-flop synchroniser for one level, frozen by the clock enable
module eipd_sync
   import eipd_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clk_en,
   input wire logic d_in,
   output logic q_out
);
   // state of the synchroniser
   typedef struct packed {
      logic [EIPD_SYNC_STAGES-1:0] stage;
   } eipd_sync_st_t;

   eipd_sync_st_t st_reg;
   eipd_sync_st_t st_next;

   // shift the pin into the chain
   always_comb begin
      st_next = st_reg;
      st_next.stage = {st_reg.stage[EIPD_SYNC_STAGES-2:0], d_in};
   end

   // register the chain
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_reg <= '0;
      end else if (clk_en) begin
         st_reg <= st_next;
      end
   end

   // only the last stage leaves the module
   assign q_out = st_reg.stage[EIPD_SYNC_STAGES-1];
endmodule

// file: hw/eipd_top.sv
// Design decisions made here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ns
// Function
// - bit 4 enables pin detection
// - bit 5 picks falling or rising polarity
// - bit 0 picks edge or edge-and-level
// - bit 6 turns internal pull off
// - rising polarity makes pull a pull-down
// - bit 3 event flag, hardware set, read-only
// - bit 2 write one clears flag, reads zero
// - level mode: ack fails while pin asserted
// - bit 1 routes flag to interrupt request
// - level mode keeps flag set while asserted
// - bit 4 also drives the registered wake enable; no pin path while clocks stopped
module eipd_top
   import eipd_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clk_en,
   input wire logic irq_pin,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output eipd_pkg::eipd_pad_t pad_ctrl,
   output logic irq_request,
   output logic wake_enable
);
   import eipd_pkg::*;

   // whole state of the block apart from the synchroniser chain in u_sync
   typedef struct packed {
      eipd_ctrl_t ctrl;          // software control bits
      logic event_flag;          // sticky event flag
      logic prev_sample;         // previous synchronised pin sample
      logic aw_held;             // write address taken, waiting for data
      logic [3:0] aw_addr;       // held write address
      logic w_held;              // write data taken, waiting for address
      logic [31:0] w_data;       // held write data
      logic w_strb0;             // held strobe of the low byte
      logic awready;             // registered ready outputs
      logic wready;
      logic arready;
      logic bvalid;              // write response pending
      logic [1:0] bresp;
      logic rvalid;              // read data pending
      logic [31:0] rdata;
      logic [1:0] rresp;
      eipd_pad_t pad;            // registered pad control
      logic irq_req;             // registered interrupt request
      logic wake_en;             // registered wake enable
   } eipd_state_t;

   eipd_state_t st_reg;
   eipd_state_t st_next;
   logic pin_sync;               // synchronised pin level

   eipd_sync u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .clk_en(clk_en),
      .d_in(irq_pin),
      .q_out(pin_sync)
   );

   // next-state logic
   always_comb begin
      logic asserted;            // pin at its asserted level
      logic prev_asserted;       // previous sample at asserted level
      logic edge_seen;           // deasserted to asserted transition
      logic level_hold;          // level mode holding the flag
      logic set_evt;             // hardware sets the flag
      logic ack_wr;              // software acknowledge this cycle
      logic do_wr;               // a write completes this cycle
      logic [3:0] wa;            // effective write address
      logic [31:0] wd;           // effective write data
      logic ws;                  // effective low-byte strobe
      asserted = 1'b0;
      prev_asserted = 1'b0;
      edge_seen = 1'b0;
      level_hold = 1'b0;
      set_evt = 1'b0;
      ack_wr = 1'b0;
      do_wr = 1'b0;
      wa = '0;
      wd = '0;
      ws = 1'b0;
      st_next = st_reg;

      asserted = st_reg.ctrl.polarity_select ? pin_sync : ~pin_sync;
      prev_asserted = st_reg.ctrl.polarity_select ? st_reg.prev_sample : ~st_reg.prev_sample;
      st_next.prev_sample = pin_sync;
      edge_seen = asserted && !prev_asserted;
      level_hold = st_reg.ctrl.detect_mode_select && asserted;
      set_evt = st_reg.ctrl.pin_function_enable && (edge_seen || level_hold);

      // write channel: take address and data in either order
      st_next.awready = 1'b0;
      st_next.wready = 1'b0;
      if (s_axi_awvalid && st_reg.awready) begin
         st_next.aw_held = 1'b1;
         st_next.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && st_reg.wready) begin
         st_next.w_held = 1'b1;
         st_next.w_data = s_axi_wdata;
         st_next.w_strb0 = s_axi_wstrb[0];
      end
      if (st_reg.aw_held && st_reg.w_held && !st_reg.bvalid) begin
         // both halves present: perform the write
         do_wr = 1'b1;
         wa = st_reg.aw_addr;
         wd = st_reg.w_data;
         ws = st_reg.w_strb0;
         st_next.aw_held = 1'b0;
         st_next.w_held = 1'b0;
         st_next.bvalid = 1'b1;
         st_next.bresp = (wa == EIPD_CTRL_ADDR) ? EIPD_RESP_OKAY : EIPD_RESP_SLVERR;
      end else begin
         // offer ready only for an empty holding slot
         st_next.awready = !st_next.aw_held && !st_reg.awready && !st_reg.bvalid;
         st_next.wready = !st_next.w_held && !st_reg.wready && !st_reg.bvalid;
      end
      if (st_reg.bvalid && s_axi_bready) begin
         // response taken
         st_next.bvalid = 1'b0;
      end

      // register write with low-byte strobe
      if (do_wr && ws && wa == EIPD_CTRL_ADDR) begin
         st_next.ctrl.pull_device_disable = wd[EIPD_PDD_BIT];
         st_next.ctrl.polarity_select = wd[EIPD_POL_BIT];
         st_next.ctrl.pin_function_enable = wd[EIPD_PE_BIT];
         st_next.ctrl.interrupt_enable = wd[EIPD_IE_BIT];
         st_next.ctrl.detect_mode_select = wd[EIPD_MODE_BIT];
         ack_wr = wd[EIPD_ACK_BIT];
      end

      if (ack_wr) begin
         st_next.event_flag = 1'b0;
      end
      if (set_evt) begin
         st_next.event_flag = 1'b1;
      end

      // read channel
      st_next.arready = 1'b0;
      if (s_axi_arvalid && st_reg.arready) begin
         st_next.rvalid = 1'b1;
         st_next.rdata = '0;
         st_next.rresp = EIPD_RESP_SLVERR;
         if (s_axi_araddr == EIPD_CTRL_ADDR) begin
            st_next.rdata[EIPD_PDD_BIT] = st_reg.ctrl.pull_device_disable;
            st_next.rdata[EIPD_POL_BIT] = st_reg.ctrl.polarity_select;
            st_next.rdata[EIPD_PE_BIT] = st_reg.ctrl.pin_function_enable;
            st_next.rdata[EIPD_FLAG_BIT] = st_reg.event_flag;
            st_next.rdata[EIPD_IE_BIT] = st_reg.ctrl.interrupt_enable;
            st_next.rdata[EIPD_MODE_BIT] = st_reg.ctrl.detect_mode_select;
            st_next.rresp = EIPD_RESP_OKAY;
         end
      end else if (st_reg.rvalid && s_axi_rready) begin
         // read data taken
         st_next.rvalid = 1'b0;
      end else if (!st_reg.rvalid && !st_reg.arready) begin
         // ready for the next read
         st_next.arready = 1'b1;
      end

      // pull on unless disabled, only when enabled
      st_next.pad.pull_enable = st_next.ctrl.pin_function_enable
         && !st_next.ctrl.pull_device_disable;
      // rising polarity turns pull into pull-down
      st_next.pad.pull_up = !st_next.ctrl.polarity_select;
      st_next.irq_req = st_next.ctrl.interrupt_enable && st_next.event_flag;
      st_next.wake_en = st_next.ctrl.pin_function_enable;
   end

   // state register, frozen while clock enable is low
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_reg <= '0;
         st_reg.ctrl <= eipd_ctrl_t'(5'h00);
         st_reg.pad.pull_up <= 1'b1;
      end else if (clk_en) begin
         st_reg <= st_next;
      end
   end

   // outputs straight from flip-flops
   assign s_axi_awready = st_reg.awready;
   assign s_axi_wready = st_reg.wready;
   assign s_axi_bresp = st_reg.bresp;
   assign s_axi_bvalid = st_reg.bvalid;
   assign s_axi_arready = st_reg.arready;
   assign s_axi_rdata = st_reg.rdata;
   assign s_axi_rresp = st_reg.rresp;
   assign s_axi_rvalid = st_reg.rvalid;
   assign pad_ctrl = st_reg.pad;
   assign irq_request = st_reg.irq_req;
   assign wake_enable = st_reg.wake_en;
endmodule

// file: test/eipd_pin_src.sv
`timescale 1ns/1ns
// pin source: drives a level, else the pull wins, else the pin wanders
module eipd_pin_src
   import eipd_pkg::*;
(
   input wire logic aclk,
   input wire logic drv_en,
   input wire logic drv_val,
   input wire eipd_pkg::eipd_pad_t pad_ctrl,
   output logic irq_pin
);
   logic wander_reg = 1'b0; // flips every cycle while nobody holds the pin
   // free toggle so a floating pin never reads as a steady level
   always_ff @(posedge aclk) begin
      wander_reg <= !wander_reg;
   end
   assign irq_pin = drv_en ? drv_val :
      (pad_ctrl.pull_enable ? pad_ctrl.pull_up : wander_reg);
endmodule

// file: test/eipd_top_sva.sv
`timescale 1ns/1ns
// port relations of the pin detector
module eipd_top_sva
   import eipd_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clk_en,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire eipd_pkg::eipd_pad_t pad_ctrl,
   input wire logic irq_request,
   input wire logic wake_enable
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_freeze_outs: assert property (
      !clk_en |=> $stable(irq_request) && $stable(pad_ctrl)) else $error("moved while frozen");
   a_reset_pads: assert property (disable iff (1'b0)
      !aresetn && clk_en |=> pad_ctrl.pull_up && !pad_ctrl.pull_enable && !irq_request)
      else $error("reset pad state wrong");
   a_pull_needs_pe: assert property (
      pad_ctrl.pull_enable |-> wake_enable) else $error("pull on with pin off");
   a_read_zeros: assert property (
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0 && !s_axi_rdata[2]) else $error("bad zeros");
   a_read_lat: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
   a_read_once: assert property (
      s_axi_arvalid && s_axi_arready |=> !s_axi_arready) else $error("ar ready held");
   a_bresp_hold: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped");
   a_rdata_hold: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped");
endmodule

// file: test/tb_top.sv
`timescale 1ns/1ns
// self-checking bench for the pin detector
module tb_top;
   import eipd_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic clk_en = 1'b1; // freeze control
   logic pin_en = 1'b1; // source holds the pin
   logic pin_val = 1'b1;
   logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
   logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic irq_pin, irq_request, wake_enable;
   eipd_pad_t pad_ctrl;
   int errors = 0, check_count = 0, cycles = 0;
   eipd_top dut (
      .aclk(aclk),
      .aresetn(aresetn),
      .clk_en(clk_en),
      .irq_pin(irq_pin),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awprot(s_axi_awprot),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arprot(s_axi_arprot),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .pad_ctrl(pad_ctrl),
      .irq_request(irq_request),
      .wake_enable(wake_enable)
   );
   eipd_pin_src src (.aclk(aclk), .drv_en(pin_en), .drv_val(pin_val), .pad_ctrl(pad_ctrl),
      .irq_pin(irq_pin));
   // 20 ns clock
   always #10 aclk = !aclk;
   // hang guard
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 3000) begin
         errors++;
         print_verdict();
      end
   end
   task automatic print_verdict();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH %s exp %0h got %0h", n, e, g);
      end
   endtask
   // write: both channels offered, each dropped when taken, late bready
   task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er);
      logic pa;
      logic pw;
      pa = 1'b1;
      pw = 1'b1;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (pa || pw) begin
         @(posedge aclk);
         pa = pa && !s_axi_awready;
         pw = pw && !s_axi_wready;
         s_axi_awvalid <= pa;
         s_axi_wvalid <= pw;
      end
      while (!s_axi_bvalid) @(posedge aclk);
      s_axi_bready <= 1'b1;
      @(posedge aclk);
      s_axi_bready <= 1'b0;
      chk("bresp", er, s_axi_bresp);
   endtask
   // read: late rready so the answer must stand
   task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      @(posedge aclk);
      while (!s_axi_arready) @(posedge aclk);
      s_axi_arvalid <= 1'b0;
      while (!s_axi_rvalid) @(posedge aclk);
      s_axi_rready <= 1'b1;
      @(posedge aclk);
      s_axi_rready <= 1'b0;
      chk("ctrl", {24'h0, e}, s_axi_rdata);
      chk("rresp", er, s_axi_rresp);
   endtask
   task automatic pin(input logic v);
      @(posedge aclk);
      pin_val <= v;
      repeat (8) @(posedge aclk);
   endtask
   task automatic t_reset();
      chk("pad", 32'h1, pad_ctrl);
      rd(4'h0, 8'h00, EIPD_RESP_OKAY);
      rd(4'h4, 8'h00, EIPD_RESP_SLVERR);
      wr(4'h4, 8'h12, EIPD_RESP_SLVERR);
      // low byte strobe off: the write must leave the register alone
      s_axi_wstrb <= 4'hE;
      wr(4'h0, 8'h12, EIPD_RESP_OKAY);
      s_axi_wstrb <= 4'hF;
      rd(4'h0, 8'h00, EIPD_RESP_OKAY);
   endtask
   task automatic t_falling();
      wr(4'h0, 8'h10, EIPD_RESP_OKAY);
      chk("pad", 32'h3, pad_ctrl);
      chk("wake", 32'h1, wake_enable);
      pin(1'b0);
      rd(4'h0, 8'h18, EIPD_RESP_OKAY);
      chk("irq", 32'h0, irq_request);
      wr(4'h0, 8'h16, EIPD_RESP_OKAY);
      rd(4'h0, 8'h12, EIPD_RESP_OKAY);
      wr(4'h0, 8'h1A, EIPD_RESP_OKAY);
      pin(1'b1);
      rd(4'h0, 8'h12, EIPD_RESP_OKAY);
      pin(1'b0);
      chk("irq", 32'h1, irq_request);
      rd(4'h0, 8'h1A, EIPD_RESP_OKAY);
   endtask
   task automatic t_level();
      wr(4'h0, 8'h74, EIPD_RESP_OKAY);
      chk("pad", 32'h0, pad_ctrl);
      wr(4'h0, 8'h33, EIPD_RESP_OKAY);
      chk("pad", 32'h2, pad_ctrl);
      rd(4'h0, 8'h33, EIPD_RESP_OKAY);
      pin(1'b1);
      chk("irq", 32'h1, irq_request);
      wr(4'h0, 8'h37, EIPD_RESP_OKAY);
      rd(4'h0, 8'h3B, EIPD_RESP_OKAY);
      pin(1'b0);
      wr(4'h0, 8'h37, EIPD_RESP_OKAY);
      rd(4'h0, 8'h33, EIPD_RESP_OKAY);
      chk("irq", 32'h0, irq_request);
   endtask
   task automatic t_disabled();
      wr(4'h0, 8'h02, EIPD_RESP_OKAY);
      pin_en <= 1'b0;
      repeat (10) @(posedge aclk);
      clk_en <= 1'b0;
      repeat (3) @(posedge aclk);
      clk_en <= 1'b1;
      pin_en <= 1'b1;
      rd(4'h0, 8'h02, EIPD_RESP_OKAY);
      chk("wake", 32'h0, wake_enable);
      chk("irq", 32'h0, irq_request);
      // falling edge arrives while frozen: seen only once the clock runs again
      wr(4'h0, 8'h12, EIPD_RESP_OKAY);
      pin(1'b1);
      @(posedge aclk);
      clk_en <= 1'b0;
      pin_val <= 1'b0;
      repeat (5) @(posedge aclk);
      chk("irq", 32'h0, irq_request);
      clk_en <= 1'b1;
      repeat (5) @(posedge aclk);
      chk("irq", 32'h1, irq_request);
   endtask
   // main sequence
   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_reset();
      t_falling();
      t_level();
      t_disabled();
      print_verdict();
   end
endmodule
bind eipd_top eipd_top_sva sva_i (
   .aclk(aclk),
   .aresetn(aresetn),
   .clk_en(clk_en),
   .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready),
   .s_axi_rdata(s_axi_rdata),
   .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready),
   .s_axi_bresp(s_axi_bresp),
   .pad_ctrl(pad_ctrl),
   .irq_request(irq_request),
   .wake_enable(wake_enable)
);
